//--- hw/flow_nulling_ctrl.v
`timescale 1ns/100ps
`default_nettype none
`include "flow_nulling_regs.vh"
module flow_nulling_ctrl #(
    parameter OK_TOL = 32'h0000_0010,
    parameter PLAUS_TOL = 32'h0000_0400
) (
    // clock and reset
    input wire sys_clk_in,
    input wire arst_n_in,
    // register access port
    input wire [15:0] reg_addr_in,
    input wire [31:0] reg_wdata_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    output reg [31:0] reg_rdata_out,
    output reg reg_rvalid_out,
    // sensor front end, same clock
    input wire sample_valid_in,
    input wire [31:0] phase_sample_in,
    input wire [31:0] period_sample_in,
    input wire sensor_ready_in,
    input wire sensor_stable_in,
    input wire [31:0] temp_corr_factor_in,
    // status
    output reg nulling_active_out
);
    // ***********************
    // reset release
    // ***********************
    reg rst_s1_q;
    reg rst_s2_q;
    wire rst_n = rst_s2_q;
    always @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end

    // ***********************
    // state and registers
    // ***********************
    localparam ST_IDLE = 2'h0;
    localparam ST_RUN = 2'h1;
    localparam ST_DIV = 2'h2;

    reg [1:0] state_q;
    reg [1:0] op_q;
    reg [15:0] sample_count_q;
    reg [15:0] countdown_q;
    reg [1:0] main_req_q;
    reg [1:0] edge_req_q;
    reg [1:0] verdict_q;
    reg soft_err_q;
    reg [31:0] temp_corr_q;
    reg [31:0] active_null_q;
    reg [31:0] prev_null_q;
    reg [31:0] running_phase_q;
    reg [31:0] stored_phase_q;
    reg [31:0] cand_offset_q;
    reg [31:0] std_dev_q;
    reg [31:0] phase_spread_q;
    reg [31:0] period_spread_q;
    reg signed [47:0] phase_sum_q;
    reg signed [31:0] phase_min_q;
    reg signed [31:0] phase_max_q;
    reg [31:0] period_min_q;
    reg [31:0] period_max_q;
    reg div_start_q;

    wire [47:0] div_quot;
    wire div_done;
    wire sum_neg = phase_sum_q[47];
    wire [47:0] sum_mag = sum_neg ? (48'h0 - phase_sum_q) : phase_sum_q;
    wire [31:0] mean = sum_neg ? (32'h0 - div_quot[31:0]) : div_quot[31:0];
    wire signed [31:0] diff = $signed(mean) - $signed(active_null_q);
    wire [31:0] diff_mag = diff[31] ? (32'h0 - diff) : diff;
    wire [31:0] phase_half = ($signed(phase_max_q) - $signed(phase_min_q)) >>> 1;
    wire [31:0] period_half = (period_max_q - period_min_q) >> 1;
    wire signed [31:0] run_step = ($signed(phase_sample_in) - $signed(running_phase_q)) >>> 4;

    seq_divider #(
        .NUM_W(48),
        .DEN_W(16)
    ) u_div (
        .sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n),
        .start_in(div_start_q),
        .num_in(sum_mag),
        .den_in(sample_count_q),
        .quot_out(div_quot),
        .done_out(div_done)
    );

    // ***********************
    // request decode
    // ***********************
    wire wr_edge = reg_wr_in && (reg_addr_in == `OFS_EDGE_REQ) && (reg_wdata_in[31:2] == 30'h0);
    wire [1:0] edge_new = reg_wdata_in[1:0];
    // calibration needs a real 0 to 1 step; the others any change
    wire edge_evt = wr_edge && (edge_new != edge_req_q) && (edge_new != `OP_NONE) &&
                    ((edge_new != `OP_CAL) || (edge_req_q == `OP_NONE)); // [R3] [R4] [R5] [R6]
    wire wr_main = reg_wr_in && (reg_addr_in == `OFS_MAIN_REQ) && (reg_wdata_in[31:2] == 30'h0);
    wire idle = (state_q == ST_IDLE);
    reg [1:0] start_op;
    always @* begin
        start_op = `OP_NONE;
        if (idle) begin // [R21]
            if (edge_evt) begin
                start_op = edge_new;
            end else if (main_req_q != `OP_NONE) begin
                start_op = main_req_q;
            end
        end
    end

    // ***********************
    // sequencer
    // ***********************
    always @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            op_q <= `OP_NONE;
            sample_count_q <= `SAMPLE_COUNT_RST;
            countdown_q <= 16'h0000;
            main_req_q <= `OP_NONE;
            edge_req_q <= `OP_NONE;
            verdict_q <= `VERDICT_NONE;
            soft_err_q <= 1'b0;
            temp_corr_q <= 32'h0000_0000;
            active_null_q <= 32'h0000_0000;
            prev_null_q <= 32'h0000_0000;
            running_phase_q <= 32'h0000_0000;
            stored_phase_q <= 32'h0000_0000;
            cand_offset_q <= 32'h0000_0000;
            std_dev_q <= 32'h0000_0000;
            phase_spread_q <= 32'h0000_0000;
            period_spread_q <= 32'h0000_0000;
            phase_sum_q <= 48'h0;
            phase_min_q <= 32'h0000_0000;
            phase_max_q <= 32'h0000_0000;
            period_min_q <= 32'h0000_0000;
            period_max_q <= 32'h0000_0000;
            div_start_q <= 1'b0;
            nulling_active_out <= 1'b0;
        end else begin
            div_start_q <= 1'b0;
            temp_corr_q <= temp_corr_factor_in; // [R18]
            // software writes
            if (reg_wr_in && (reg_addr_in == `OFS_SAMPLE_COUNT) && (reg_wdata_in[31:16] == 16'h0) &&
                (reg_wdata_in[15:0] >= `SAMPLE_COUNT_MIN) && (reg_wdata_in[15:0] <= `SAMPLE_COUNT_MAX) && idle) begin
                sample_count_q <= reg_wdata_in[15:0]; // [R1]
            end
            if (wr_edge) begin
                edge_req_q <= edge_new;
            end
            if (wr_main && idle) begin
                main_req_q <= reg_wdata_in[1:0];
            end
            if (reg_wr_in && (reg_addr_in == `OFS_PHASE_SPREAD)) begin
                phase_spread_q <= reg_wdata_in;
            end
            if (reg_wr_in && (reg_addr_in == `OFS_PERIOD_SPREAD)) begin
                period_spread_q <= reg_wdata_in;
            end
            case (state_q)
                ST_IDLE: begin
                    if (start_op == `OP_INST) begin
                        if (verdict_q != `VERDICT_NONE) begin
                            prev_null_q <= active_null_q; // [R13]
                            active_null_q <= cand_offset_q; // [R5]
                            verdict_q <= `VERDICT_NONE; // [R9]
                        end else begin
                            soft_err_q <= 1'b1; // [R20]
                        end
                        main_req_q <= `OP_NONE; // [R19]
                    end else if (start_op != `OP_NONE) begin
                        if (sensor_ready_in) begin
                            soft_err_q <= 1'b0;
                            op_q <= start_op;
                            state_q <= ST_RUN;
                            countdown_q <= sample_count_q; // [R7]
                            nulling_active_out <= 1'b1; // [R8]
                            phase_sum_q <= 48'h0;
                            phase_min_q <= 32'h7fff_ffff;
                            phase_max_q <= 32'h8000_0000;
                            period_min_q <= 32'hffff_ffff;
                            period_max_q <= 32'h0000_0000;
                            running_phase_q <= 32'h0000_0000;
                        end else begin
                            soft_err_q <= 1'b1; // [R20]
                            main_req_q <= `OP_NONE; // [R19]
                        end
                    end
                end
                ST_RUN: begin
                    if (!sensor_stable_in) begin
                        soft_err_q <= 1'b1; // [R20]
                        countdown_q <= 16'h0000;
                        nulling_active_out <= 1'b0;
                        main_req_q <= `OP_NONE; // [R19]
                        state_q <= ST_IDLE;
                    end else if (sample_valid_in) begin
                        // one sample per oscillation period
                        phase_sum_q <= phase_sum_q + {{16{phase_sample_in[31]}}, phase_sample_in}; // [R2]
                        running_phase_q <= running_phase_q + run_step; // [R12]
                        if ($signed(phase_sample_in) < phase_min_q) begin
                            phase_min_q <= phase_sample_in;
                        end
                        if ($signed(phase_sample_in) > phase_max_q) begin
                            phase_max_q <= phase_sample_in;
                        end
                        if (period_sample_in < period_min_q) begin
                            period_min_q <= period_sample_in;
                        end
                        if (period_sample_in > period_max_q) begin
                            period_max_q <= period_sample_in;
                        end
                        countdown_q <= countdown_q - 16'h0001; // [R7]
                        if (countdown_q == 16'h0001) begin
                            state_q <= ST_DIV;
                            div_start_q <= 1'b1;
                        end
                    end
                end
                ST_DIV: begin
                    // the run still counts as active here, so instability aborts it too
                    if (!sensor_stable_in) begin
                        soft_err_q <= 1'b1; // [R20]
                        nulling_active_out <= 1'b0;
                        main_req_q <= `OP_NONE; // [R19]
                        state_q <= ST_IDLE;
                    end else if (div_done) begin
                        stored_phase_q <= mean; // [R12]
                        phase_spread_q <= phase_half; // [R16]
                        period_spread_q <= period_half; // [R17]
                        if (op_q == `OP_CAL) begin
                            prev_null_q <= active_null_q; // [R13]
                            active_null_q <= mean; // [R3] [R11]
                        end else begin
                            cand_offset_q <= mean; // [R4] [R14]
                            std_dev_q <= phase_half; // [R15]
                            // spread or distance too large means do not trust it
                            if ((phase_half > PLAUS_TOL) || (diff_mag > PLAUS_TOL)) begin
                                verdict_q <= `VERDICT_BAD; // [R9]
                            end else if (diff_mag > OK_TOL) begin
                                verdict_q <= `VERDICT_UPDATE; // [R9] [R10]
                            end else begin
                                verdict_q <= `VERDICT_VALID; // [R9]
                            end
                        end
                        nulling_active_out <= 1'b0; // [R8]
                        main_req_q <= `OP_NONE; // [R19]
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // ***********************
    // read port
    // ***********************
    reg [31:0] rd_mux;
    always @* begin
        case (reg_addr_in)
            `OFS_SOFT_ERROR: rd_mux = {21'h0, soft_err_q, 10'h0};
            `OFS_TEMP_CORR: rd_mux = temp_corr_q;
            `OFS_ACTIVE_NULL: rd_mux = active_null_q;
            `OFS_RUNNING_PHASE: rd_mux = running_phase_q;
            `OFS_COUNTDOWN: rd_mux = {16'h0, countdown_q};
            `OFS_PREV_NULL: rd_mux = prev_null_q;
            `OFS_ACTIVE_FLAG: rd_mux = {31'h0, nulling_active_out};
            `OFS_VERDICT: rd_mux = {30'h0, verdict_q};
            `OFS_CAND_OFFSET: rd_mux = cand_offset_q;
            `OFS_STD_DEV: rd_mux = std_dev_q;
            `OFS_MAIN_REQ: rd_mux = {30'h0, main_req_q};
            `OFS_STORED_PHASE: rd_mux = stored_phase_q;
            `OFS_PHASE_SPREAD: rd_mux = phase_spread_q;
            `OFS_PERIOD_SPREAD: rd_mux = period_spread_q;
            `OFS_SAMPLE_COUNT: rd_mux = {16'h0, sample_count_q};
            `OFS_EDGE_REQ: rd_mux = {30'h0, edge_req_q};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_out <= 32'h0000_0000;
            reg_rvalid_out <= 1'b0;
        end else begin
            reg_rvalid_out <= reg_rd_in;
            reg_rdata_out <= reg_rd_in ? rd_mux : 32'h0000_0000;
        end
    end
endmodule
`default_nettype wire

//--- hw/flow_nulling_regs.vh
// Notes on behaviour
// R1 - sample-count setting accepts 1 to 8000 and resets to 500
// R2 - a run gathers sample-count samples, one per sensor oscillation period
// R3 - edge request word going 0 to 1 starts a calibration run
// R4 - edge request word going to 2 starts verification; result not installed
// R5 - edge request word going to 3 installs the last verification result
// R6 - host writes 0 to the edge request word between requests
// R7 - countdown reads 0 when done, else the samples still to take
// R8 - activity flag reads 1 during a run, 0 otherwise
// R9 - verdict: 0 none, 1 offset valid, 2 update advised, 3 implausible
// R10 - on verdict 2 the host may write 3 to the main request register
// R11 - active null offset is reported as a phase in 8 ns units
// R12 - running phase shown during a run; final value goes to holding register
// R13 - previous active offset is saved before a run replaces it
// R14 - verification result goes to its own register, qualified by the verdict
// R15 - standard deviation of the verification candidate is kept
// R16 - phase-spread diagnostic is kept after each run
// R17 - period-spread diagnostic is kept after each run
// R18 - current temperature correction factor is reported continuously
// R19 - main request register returns to 0 when its operation concludes
// R20 - a failed nulling operation sets bit 10 of the soft-error status
// R21 - start requests arriving while a run is active are ignored
`ifndef FLOW_NULLING_REGS_VH
`define FLOW_NULLING_REGS_VH

// ***********************
// register offsets
// ***********************
`define OFS_SOFT_ERROR 16'h401c
`define OFS_TEMP_CORR 16'h4700
`define OFS_ACTIVE_NULL 16'h4702
`define OFS_RUNNING_PHASE 16'h4704
`define OFS_COUNTDOWN 16'h4706
`define OFS_PREV_NULL 16'h4708
`define OFS_ACTIVE_FLAG 16'h470a
`define OFS_VERDICT 16'h470c
`define OFS_CAND_OFFSET 16'h470e
`define OFS_STD_DEV 16'h4710
`define OFS_MAIN_REQ 16'h6718
`define OFS_STORED_PHASE 16'h671a
`define OFS_PHASE_SPREAD 16'h6724
`define OFS_PERIOD_SPREAD 16'h6726
`define OFS_SAMPLE_COUNT 16'h6728
`define OFS_EDGE_REQ 16'h672a

// ***********************
// fields and reset values
// ***********************
`define SOFT_ERR_NULL_BIT 10
`define SAMPLE_COUNT_RST 16'h01f4
`define SAMPLE_COUNT_MIN 16'h0001
`define SAMPLE_COUNT_MAX 16'h1f40
`define OP_NONE 2'h0
`define OP_CAL 2'h1
`define OP_VER 2'h2
`define OP_INST 2'h3
`define VERDICT_NONE 2'h0
`define VERDICT_VALID 2'h1
`define VERDICT_UPDATE 2'h2
`define VERDICT_BAD 2'h3

`endif

//--- hw/seq_divider.v
`timescale 1ns/100ps
`default_nettype none
// restoring divider, one quotient bit per clock
module seq_divider #(
    parameter NUM_W = 48,
    parameter DEN_W = 16
) (
    input wire sys_clk_in,
    input wire rst_n_in,
    input wire start_in,
    input wire [NUM_W-1:0] num_in,
    input wire [DEN_W-1:0] den_in,
    output reg [NUM_W-1:0] quot_out,
    output reg done_out
);
    reg [NUM_W-1:0] num_q;
    reg [DEN_W:0] rem_q;
    reg [DEN_W-1:0] den_q;
    reg [7:0] cnt_q;
    reg busy_q;
    localparam [7:0] CNT_LOAD = NUM_W;
    wire [DEN_W:0] shifted = {rem_q[DEN_W-1:0], num_q[NUM_W-1]};
    wire fits = shifted >= {1'b0, den_q};

    always @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            num_q <= {NUM_W{1'b0}};
            rem_q <= {(DEN_W+1){1'b0}};
            den_q <= {DEN_W{1'b0}};
            cnt_q <= 8'h00;
            busy_q <= 1'b0;
            quot_out <= {NUM_W{1'b0}};
            done_out <= 1'b0;
        end else begin
            done_out <= 1'b0;
            if (start_in) begin
                num_q <= num_in;
                den_q <= den_in;
                rem_q <= {(DEN_W+1){1'b0}};
                cnt_q <= CNT_LOAD;
                busy_q <= 1'b1;
            end else if (busy_q) begin
                rem_q <= fits ? (shifted - {1'b0, den_q}) : shifted;
                num_q <= {num_q[NUM_W-2:0], fits};
                cnt_q <= cnt_q - 8'h01;
                if (cnt_q == 8'h01) begin
                    busy_q <= 1'b0;
                    done_out <= 1'b1;
                    quot_out <= {num_q[NUM_W-2:0], fits};
                end
            end
        end
    end
endmodule
`default_nettype wire

//--- verif/flow_nulling_ctrl_props.sv
`timescale 1ns/100ps
`default_nettype none
module flow_nulling_ctrl_props (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic arst_n_in,
    // register port
    input wire logic [15:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [31:0] reg_rdata_out,
    input wire logic reg_rvalid_out,
    // sensor side and status
    input wire logic sensor_ready_in,
    input wire logic sensor_stable_in,
    input wire logic [31:0] temp_corr_factor_in,
    input wire logic nulling_active_out
);
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!arst_n_in);
    // ****************
    // register reads
    // ****************
    flag_read_a: assert property (reg_rd_in && reg_addr_in == 16'h470a |=> reg_rvalid_out && reg_rdata_out == {31'h0, $past(nulling_active_out)}) else $error("activity flag read wrong");
    count_range_a: assert property (reg_rd_in && reg_addr_in == 16'h6728 |=> reg_rdata_out >= 32'h1 && reg_rdata_out <= 32'h1f40) else $error("sample count out of range");
    idle_countdown_a: assert property (reg_rd_in && reg_addr_in == 16'h4706 && !nulling_active_out |=> reg_rdata_out == 32'h0) else $error("countdown not zero when idle");
    verdict_range_a: assert property (reg_rd_in && reg_addr_in == 16'h470c |=> reg_rvalid_out && reg_rdata_out[31:2] == 30'h0) else $error("verdict code out of range");
    temp_read_a: assert property (reg_rd_in && reg_addr_in == 16'h4700 && $stable(temp_corr_factor_in) && temp_corr_factor_in == $past(temp_corr_factor_in, 2) |=> reg_rdata_out == $past(temp_corr_factor_in)) else $error("correction factor read wrong");
    // ****************
    // run control
    // ****************
    cal_start_a: assert property (reg_wr_in && reg_addr_in == 16'h6718 && reg_wdata_in == 32'h1 && !nulling_active_out ##1 sensor_ready_in |=> nulling_active_out) else $error("calibration did not start");
    ver_start_a: assert property (reg_wr_in && reg_addr_in == 16'h6718 && reg_wdata_in == 32'h2 && !nulling_active_out ##1 sensor_ready_in |=> nulling_active_out) else $error("verification did not start");
    no_start_a: assert property (reg_wr_in && reg_addr_in == 16'h6718 && !nulling_active_out && !sensor_ready_in ##1 !sensor_ready_in |=> !nulling_active_out [*2]) else $error("run started with sensor not ready");
    abort_a: assert property (nulling_active_out && !sensor_stable_in |=> !nulling_active_out) else $error("unstable sensor did not abort");
endmodule
bind flow_nulling_ctrl flow_nulling_ctrl_props u_props (.sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out), .sensor_ready_in(sensor_ready_in),
    .sensor_stable_in(sensor_stable_in), .temp_corr_factor_in(temp_corr_factor_in),
    .nulling_active_out(nulling_active_out));
`default_nettype wire

//--- verif/sensor_front_model.sv
`timescale 1ns/100ps
`default_nettype none
module sensor_front_model #(
    parameter PERIOD_VAL = 32'h0000_1000
) (
    input wire logic clk_in,
    input wire logic samp_en_in,
    input wire logic [31:0] phase_val_in,
    output logic sample_valid_out,
    output logic [31:0] phase_out,
    output logic [31:0] period_out
);
    logic [1:0] cnt_q = 2'h0;
    // one sample every fourth cycle, as one sensor period
    always @(posedge clk_in) begin
        cnt_q <= cnt_q + 2'h1;
        sample_valid_out <= samp_en_in && cnt_q == 2'h3;
    end
    // between samples the lines carry junk, so stale values are never taken
    assign phase_out = sample_valid_out ? phase_val_in : ~phase_val_in;
    assign period_out = sample_valid_out ? PERIOD_VAL : ~PERIOD_VAL;
endmodule
`default_nettype wire

//--- verif/test_flow_nulling_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
`include "flow_nulling_regs.vh"
module test_flow_nulling_ctrl;
    logic sys_clk_in = 1'b0;
    logic arst_n_in = 1'b0;
    logic [15:0] reg_addr_in = 16'h0;
    logic [31:0] reg_wdata_in = 32'h0;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic samp_en = 1'b0;
    logic ready = 1'b1;
    logic stable = 1'b1;
    logic [31:0] phase_val = 32'h0;
    logic [31:0] temp_val = 32'h0;
    logic [31:0] cur_null = 32'h0;
    wire logic [31:0] rdata;
    wire logic rvalid;
    wire logic active;
    wire logic svalid;
    wire logic [31:0] sphase;
    wire logic [31:0] speriod;
    int bad_count = 0;
    int n_tests = 0;
    int cyc = 0;
    integer seed = 32'h155a64fc;
    logic [31:0] exp_q[$];
    string name_q[$];
    logic [31:0] ph_tab[4] = '{32'h8, 32'h800, 32'h100, 32'h140};
    logic [31:0] vd_tab[4] = '{32'h1, 32'h3, 32'h2, 32'h2};

    flow_nulling_ctrl u_flow_nulling_ctrl (.sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_rdata_out(rdata), .reg_rvalid_out(rvalid), .sample_valid_in(svalid), .phase_sample_in(sphase),
        .period_sample_in(speriod), .sensor_ready_in(ready), .sensor_stable_in(stable),
        .temp_corr_factor_in(temp_val), .nulling_active_out(active));
    sensor_front_model u_sensor_front_model (.clk_in(sys_clk_in), .samp_en_in(samp_en), .phase_val_in(phase_val),
        .sample_valid_out(svalid), .phase_out(sphase), .period_out(speriod));

    initial begin
        forever #4 sys_clk_in = ~sys_clk_in;
    end
    // ****************
    // shared tasks
    // ****************
    task automatic end_of_test();
        if (bad_count == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic reg_write(input logic [15:0] addr, input logic [31:0] data);
        @(posedge sys_clk_in);
        #1;
        reg_addr_in = addr;
        reg_wdata_in = data;
        reg_wr_in = 1'b1;
        @(posedge sys_clk_in);
        #1;
        reg_wr_in = 1'b0;
    endtask
    task automatic reg_read(input logic [15:0] addr, input logic [31:0] exp, input string what);
        exp_q.push_back(exp);
        name_q.push_back(what);
        @(posedge sys_clk_in);
        #1;
        reg_addr_in = addr;
        reg_rd_in = 1'b1;
        @(posedge sys_clk_in);
        #1;
        reg_rd_in = 1'b0;
    endtask
    // lets samples flow until the run ends; a short run means samples were skipped
    task automatic run_to_end(input int count);
        int n;
        n = 0;
        samp_en = 1'b1;
        while (active !== 1'b0 && n < 3000) begin
            @(posedge sys_clk_in);
            #1;
            n++;
        end
        samp_en = 1'b0;
        check("run end", 32'h0, {31'h0, active});
        check("run long enough", 32'h1, {31'h0, n >= 4 * (count - 1) + 49});
    endtask
    task automatic run_op(input logic [15:0] addr, input logic [31:0] op, input logic [31:0] count);
        reg_write(addr, op);
        reg_read(`OFS_COUNTDOWN, count, "countdown");
        reg_read(`OFS_ACTIVE_FLAG, 32'h1, "active flag");
        run_to_end(count);
        reg_read(`OFS_COUNTDOWN, 32'h0, "countdown done");
        reg_read(`OFS_MAIN_REQ, 32'h0, "main request");
        if (addr == `OFS_EDGE_REQ) begin
            reg_write(`OFS_EDGE_REQ, 32'h0);
        end
    endtask
    task automatic check_null(input logic [31:0] prev, input logic [31:0] verdict);
        reg_read(`OFS_ACTIVE_NULL, cur_null, "active offset");
        reg_read(`OFS_PREV_NULL, prev, "previous offset");
        reg_read(`OFS_VERDICT, verdict, "verdict");
    endtask
    // ****************
    // result checking
    // ****************
    always @(negedge sys_clk_in) begin
        if (rvalid === 1'b1) begin
            if (exp_q.size() == 0) begin
                check("unasked read answer", 32'h0, 32'h1);
            end else begin
                check(name_q.pop_front(), exp_q.pop_front(), rdata);
            end
        end
    end
    always @(posedge sys_clk_in) begin
        cyc++;
        if (cyc == 20000) begin
            check("timeout", 32'h0, 32'h1);
            end_of_test();
        end
    end
    // ****************
    // scenarios
    // ****************
    initial begin
        repeat (8) @(posedge sys_clk_in);
        #1;
        arst_n_in = 1'b1;
        repeat (3) @(posedge sys_clk_in);
        reg_read(`OFS_SAMPLE_COUNT, 32'h1f4, "count reset");
        check_null(32'h0, 32'h0);
        reg_write(`OFS_SAMPLE_COUNT, 32'h0);
        reg_write(`OFS_SAMPLE_COUNT, 32'h1f41);
        reg_read(`OFS_SAMPLE_COUNT, 32'h1f4, "count refused");
        reg_write(`OFS_SAMPLE_COUNT, 32'h1f40);
        reg_read(`OFS_SAMPLE_COUNT, 32'h1f40, "count max");
        reg_write(`OFS_SAMPLE_COUNT, 32'h5);
        for (int i = 0; i < 4; i++) begin
            phase_val = ph_tab[i];
            run_op(i[0] ? `OFS_MAIN_REQ : `OFS_EDGE_REQ, 32'h2, 32'h5);
            check_null(32'h0, vd_tab[i]);
            reg_read(`OFS_CAND_OFFSET, ph_tab[i], "candidate");
            reg_read(`OFS_STORED_PHASE, ph_tab[i], "stored phase");
            reg_read(`OFS_STD_DEV, 32'h0, "std dev");
            reg_read(`OFS_PHASE_SPREAD, 32'h0, "phase spread");
            reg_read(`OFS_PERIOD_SPREAD, 32'h0, "period spread");
            if (i == 2) begin
                reg_write(`OFS_MAIN_REQ, 32'h3);
                cur_null = 32'h100;
                check_null(32'h0, 32'h0);
            end
        end
        reg_write(`OFS_EDGE_REQ, 32'h3);
        cur_null = 32'h140;
        check_null(32'h100, 32'h0);
        reg_write(`OFS_EDGE_REQ, 32'h0);
        reg_write(`OFS_EDGE_REQ, 32'h3);
        reg_read(`OFS_SOFT_ERROR, 32'h400, "install with no result");
        check_null(32'h100, 32'h0);
        reg_write(`OFS_EDGE_REQ, 32'h0);
        reg_write(`OFS_SAMPLE_COUNT, 32'h1);
        phase_val = 32'h40;
        run_op(`OFS_EDGE_REQ, 32'h1, 32'h1);
        cur_null = 32'h40;
        check_null(32'h140, 32'h0);
        reg_read(`OFS_SOFT_ERROR, 32'h0, "soft error cleared");
        phase_val = 32'h44;
        reg_write(`OFS_MAIN_REQ, 32'h1);
        reg_write(`OFS_MAIN_REQ, 32'h2);
        run_to_end(1);
        repeat (4) @(posedge sys_clk_in);
        reg_read(`OFS_ACTIVE_FLAG, 32'h0, "no second run");
        reg_read(`OFS_MAIN_REQ, 32'h0, "main request");
        cur_null = 32'h44;
        check_null(32'h40, 32'h0);
        ready = 1'b0;
        reg_write(`OFS_MAIN_REQ, 32'h1);
        reg_read(`OFS_MAIN_REQ, 32'h0, "failed start");
        reg_read(`OFS_SOFT_ERROR, 32'h400, "not ready");
        ready = 1'b1;
        reg_write(`OFS_SAMPLE_COUNT, 32'h5);
        reg_write(`OFS_MAIN_REQ, 32'h1);
        reg_read(`OFS_ACTIVE_FLAG, 32'h1, "abort run");
        stable = 1'b0;
        repeat (2) @(posedge sys_clk_in);
        #1;
        stable = 1'b1;
        reg_read(`OFS_ACTIVE_FLAG, 32'h0, "aborted");
        reg_read(`OFS_COUNTDOWN, 32'h0, "aborted count");
        reg_read(`OFS_SOFT_ERROR, 32'h400, "abort error");
        reg_write(`OFS_ACTIVE_NULL, 32'hdead);
        check_null(32'h40, 32'h0);
        reg_read(16'h1234, 32'h0, "unmapped");
        for (int i = 0; i < 3; i++) begin
            temp_val = $random(seed);
            repeat (3) @(posedge sys_clk_in);
            reg_read(`OFS_TEMP_CORR, temp_val, "temp factor");
        end
        repeat (4) @(posedge sys_clk_in);
        check("pending reads", 32'h0, exp_q.size());
        end_of_test();
    end
endmodule
`default_nettype wire
